//--- hdl/sttc_top.sv
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module sttc_top (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // controller inputs
  input  wire logic                step_i,
  input  wire logic                dir_i,
  input  wire logic                resolution_select_i,
  input  wire logic                outputs_off_i,
  input  wire logic                translator_rst_n_i,
  // supervision inputs
  input  wire logic                overtemp_i,
  input  wire logic                gate_drive_reservoir_low_i,
  input  wire logic                sink_gate_regulator_fault_i,
  input  wire logic                undervoltage_lockout_i,
  input  wire logic                off_time_timing_pin_high_i,
  // current sense
  input  wire logic [1:0]          trip_i,
  input  wire logic [1:0]          zero_i,
  // bridge, reference and position outputs
  output sttc_pkg::sttc_drv_t      bridge1_o,
  output sttc_pkg::sttc_drv_t      bridge2_o,
  output sttc_pkg::sttc_dac_t      dac1_o,
  output sttc_pkg::sttc_dac_t      dac2_o,
  output logic      [2:0]          pos_o,
  output logic                     home_o
);
  import sttc_pkg::*;

  typedef struct packed {
    sttc_pins_t  s1;
    sttc_pins_t  s2;
    sttc_pins_t  s3;
    sttc_pins_t  flt;
    logic [2:0]  pos;
    logic [1:0]  mixed;
    logic [15:0] steps;
    logic [15:0] ohms;
    logic        run;
    logic        home;
    sttc_lvl_t   lvl1;
    sttc_lvl_t   lvl2;
    sttc_dac_t   dac1;
    sttc_dac_t   dac2;
    logic        ack;
    logic [31:0] dat;
  } sttc_st_t;

  sttc_st_t     r_ff;
  sttc_st_t     nxt_r;
  sttc_pins_t   pins;
  sttc_status_t stat;
  sttc_lvl_t    new1;
  sttc_lvl_t    new2;
  logic [15:0]  ohms_eff;
  logic         rise;
  logic         req;
  logic [2:0]   npos;

  // next translator position for one step edge
  function automatic logic [2:0] step_pos(
    input logic [2:0] p,
    input logic       up,
    input logic       half
  );
    logic [2:0] d;
    d = (half || !p[0]) ? 3'h1 : 3'h2;
    return up ? p + d : p - d;
  endfunction

  // gather the pins into one word
  always_comb begin
    pins.step     = step_i;
    pins.dir      = dir_i;
    pins.res      = resolution_select_i;
    pins.off      = outputs_off_i;
    pins.rst_n    = translator_rst_n_i;
    pins.otemp    = overtemp_i;
    pins.cap_low  = gate_drive_reservoir_low_i;
    pins.reg_flt  = sink_gate_regulator_fault_i;
    pins.lockout  = undervoltage_lockout_i;
    pins.tpin_hi  = off_time_timing_pin_high_i;
    pins.trip     = trip_i;
    pins.zero     = zero_i;
  end

  // status word seen by software
  always_comb begin
    stat.steps   = r_ff.steps;
    stat.rsv     = 1'b0;
    stat.dir     = r_ff.flt.dir;
    stat.res     = r_ff.flt.res;
    stat.tpin_hi = r_ff.flt.tpin_hi;
    stat.rst_n   = r_ff.flt.rst_n;
    stat.faults  = {r_ff.flt.off, r_ff.flt.otemp, r_ff.flt.cap_low,
                    r_ff.flt.reg_flt, r_ff.flt.lockout};
    stat.run     = r_ff.run;
    stat.mixed   = r_ff.mixed;
    stat.pos     = r_ff.pos;
  end

  // effective off-time setting in ohms
  assign ohms_eff = r_ff.flt.tpin_hi ? OHM_DEFAULT : r_ff.ohms; // R3 R2

  // synchronisers, translator, supervision and register bus
  always_comb begin
    nxt_r = r_ff;
    new1  = '0;
    new2  = '0;
    npos  = r_ff.pos;
    // three stages; a change counts once stages two and three agree
    nxt_r.s1  = pins;
    nxt_r.s2  = r_ff.s1;
    nxt_r.s3  = r_ff.s2;
    nxt_r.flt = (r_ff.s2 & r_ff.s3) | (r_ff.flt & (r_ff.s2 ^ r_ff.s3));
    rise = nxt_r.flt.step && !r_ff.flt.step; // R15

    // translator works regardless of the disable input
    if (!nxt_r.flt.rst_n || nxt_r.flt.lockout) begin
      nxt_r.pos   = HOME_POS; // R18 R8 R14
      nxt_r.mixed = 2'b11;
    end else if (rise) begin // R6
      npos = step_pos(r_ff.pos, nxt_r.flt.dir, nxt_r.flt.res); // R19 R20 R16
      new1 = sttc_lvl_of(npos); // R13
      new2 = sttc_lvl_of(npos - 3'h2);
      nxt_r.pos      = npos;
      nxt_r.mixed[0] = new1.mag < r_ff.lvl1.mag; // R17
      nxt_r.mixed[1] = new2.mag < r_ff.lvl2.mag; // R17
      nxt_r.steps    = r_ff.steps + 16'h0001;
    end

    // current levels and reference outputs follow the position
    nxt_r.lvl1      = sttc_lvl_of(nxt_r.pos); // R13
    nxt_r.lvl2      = sttc_lvl_of(nxt_r.pos - 3'h2);
    nxt_r.dac1.neg  = nxt_r.lvl1.neg;
    nxt_r.dac1.pct  = sttc_pct_of(nxt_r.lvl1.mag);
    nxt_r.dac2.neg  = nxt_r.lvl2.neg;
    nxt_r.dac2.pct  = sttc_pct_of(nxt_r.lvl2.mag);
    nxt_r.home      = nxt_r.pos == HOME_POS; // R14

    // any disable or fault stops both bridges while it lasts
    nxt_r.run = nxt_r.flt.rst_n      // R18
             && !nxt_r.flt.off       // R5
             && !nxt_r.flt.otemp     // R7
             && !nxt_r.flt.cap_low   // R7
             && !nxt_r.flt.reg_flt   // R9
             && !nxt_r.flt.lockout;  // R8

    // classic wishbone: ack one cycle after the request, then drop
    req       = wb_cyc_i && wb_stb_i && !r_ff.ack;
    nxt_r.ack = req;
    nxt_r.dat = '0;
    // a write lands at the edge where the master samples ack high
    if (r_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == REG_TIMING) begin
      if (wb_sel_i[0]) begin
        nxt_r.ohms[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_r.ohms[15:8] = wb_dat_i[15:8];
      end
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_TIMING: nxt_r.dat = {16'h0000, r_ff.ohms};
        REG_STATUS: nxt_r.dat = stat;
        REG_LEVELS: nxt_r.dat = {1'b0, r_ff.dac2, 1'b0, r_ff.dac1};
        default:    nxt_r.dat = '0;
      endcase
    end
  end

  // state register; reset acts as power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff       <= '0;
      r_ff.pos   <= HOME_POS; // R8
      r_ff.home  <= 1'b1;
      r_ff.mixed <= 2'b11;
      r_ff.ohms  <= OHM_DEFAULT;
      r_ff.lvl1  <= '{neg: 1'b0, mag: MAG_707};
      r_ff.lvl2  <= '{neg: 1'b0, mag: MAG_707};
      r_ff.dac1  <= '{neg: 1'b0, pct: PCT_707};
      r_ff.dac2  <= '{neg: 1'b0, pct: PCT_707};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // phase 1 chopper
  sttc_chop u_chop1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (r_ff.run),
    .mixed_i (r_ff.mixed[0]),
    .trip_i  (r_ff.flt.trip[0]),
    .zero_i  (r_ff.flt.zero[0]),
    .lvl_i   (r_ff.lvl1),
    .ohms_i  (ohms_eff),
    .drv_o   (bridge1_o)
  );

  // phase 2 chopper
  sttc_chop u_chop2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (r_ff.run),
    .mixed_i (r_ff.mixed[1]),
    .trip_i  (r_ff.flt.trip[1]),
    .zero_i  (r_ff.flt.zero[1]),
    .lvl_i   (r_ff.lvl2),
    .ohms_i  (ohms_eff),
    .drv_o   (bridge2_o)
  );

  // registered outputs
  assign wb_dat_o = r_ff.dat;
  assign wb_ack_o = r_ff.ack;
  assign dac1_o   = r_ff.dac1;
  assign dac2_o   = r_ff.dac2;
  assign pos_o    = r_ff.pos;
  assign home_o   = r_ff.home;

endmodule // sttc_top

//--- common/sttc_pkg.sv
// Summary of operation
// [R1] after a trip, one-shot holds drive off
// [R2] off-time is timing resistance over 825
// [R3] timing pin high selects 30 us off-time
// [R4] comparator ignored 1 us after switching
// [R5] disable input high forces bridges off
// [R6] translator keeps stepping while disabled
// [R7] overtemp or reservoir low stops bridges
// [R8] power-on lockout: bridges off, translator home
// [R9] regulator fault stops the bridges
// [R10] mixed decay: fast 31.25 percent, then slow
// [R11] off-period turns on matching recirculation transistors
// [R12] zero current ends synchronous rectification
// [R13] eight half-step positions, signed current table
// [R14] home is position 2, both 70.71
// [R15] each step rising edge moves one increment
// [R16] resolution low full-step, high half-step
// [R17] falling level mixed decay, else slow
// [R18] reset low: home, off, steps ignored
// [R19] direction sampled at step, wraps modulo eight
// [R20] full-step moves two, odd snaps adjacent
package sttc_pkg;

  // time base
  localparam int CLK_MHZ        = 25;
  localparam int CLK_NS         = 40;
  localparam int OHM_PER_US     = 825;
  localparam int OFF_DEFAULT_US = 30;
  localparam int BLANK_NS       = 1000;
  localparam int BLANK_CYC      = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAST_NUM       = 5;  // 5/16 = 31.25 percent
  localparam int FAST_SHIFT     = 4;

  localparam logic [16:0] ACC_STEP    = 17'(OHM_PER_US / CLK_MHZ);
  localparam logic [15:0] OHM_DEFAULT = 16'(OFF_DEFAULT_US * OHM_PER_US);
  localparam logic [4:0]  BLANK_LOAD  = 5'(BLANK_CYC);

  // translator
  localparam logic [2:0]  HOME_POS = 3'h1;  // half-step position 2
  localparam logic [1:0]  MAG_ZERO = 2'h0;
  localparam logic [1:0]  MAG_707  = 2'h1;
  localparam logic [1:0]  MAG_FULL = 2'h2;
  localparam logic [13:0] PCT_ZERO = 14'h0000;
  localparam logic [13:0] PCT_707  = 14'h1b9f;  // 70.71 in hundredths
  localparam logic [13:0] PCT_FULL = 14'h2710;  // 100.00 in hundredths

  // register map offsets
  localparam logic [3:0]  REG_TIMING = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_LEVELS = 4'h8;

  typedef struct packed {
    logic       step;
    logic       dir;
    logic       res;
    logic       off;
    logic       rst_n;
    logic       otemp;
    logic       cap_low;
    logic       reg_flt;
    logic       lockout;
    logic       tpin_hi;
    logic [1:0] trip;
    logic [1:0] zero;
  } sttc_pins_t;

  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } sttc_drv_t;

  typedef struct packed {
    logic       neg;
    logic [1:0] mag;
  } sttc_lvl_t;

  typedef struct packed {
    logic        neg;
    logic [13:0] pct;
  } sttc_dac_t;

  typedef struct packed {
    logic [15:0] steps;
    logic        rsv;
    logic        dir;
    logic        res;
    logic        tpin_hi;
    logic        rst_n;
    logic [4:0]  faults;
    logic        run;
    logic [1:0]  mixed;
    logic [2:0]  pos;
  } sttc_status_t;

  typedef enum logic [1:0] {
    CH_ON  = 2'b01,
    CH_OFF = 2'b10
  } sttc_ch_t;

  // phase 1 level at a position; phase 2 is phase 1 two positions back
  function automatic sttc_lvl_t sttc_lvl_of(input logic [2:0] p);
    sttc_lvl_t l;
    l.neg = p inside {3'h3, 3'h4, 3'h5};
    case (p)
      3'h0, 3'h4: l.mag = MAG_FULL;
      3'h2, 3'h6: l.mag = MAG_ZERO;
      default:    l.mag = MAG_707;
    endcase
    return l;
  endfunction

  function automatic logic [13:0] sttc_pct_of(input logic [1:0] m);
    case (m)
      MAG_FULL: return PCT_FULL;
      MAG_707:  return PCT_707;
      default:  return PCT_ZERO;
    endcase
  endfunction

endpackage

//--- hdl/sttc_chop.sv
`timescale 1ns/1ps
module sttc_chop (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                run_i,
  input  wire logic                mixed_i,
  input  wire logic                trip_i,
  input  wire logic                zero_i,
  input  sttc_pkg::sttc_lvl_t      lvl_i,
  input  wire logic [15:0]         ohms_i,
  output sttc_pkg::sttc_drv_t      drv_o
);
  import sttc_pkg::*;

  typedef struct packed {
    sttc_ch_t    st;
    logic [16:0] acc;
    logic [4:0]  blank;
    logic        zoff;
    sttc_drv_t   drv;
  } sttc_chs_t;

  sttc_chs_t r_ff;
  sttc_chs_t nxt_r;
  sttc_drv_t dv;
  logic      fast;

  // one-shot off-time, decay phases and blanking
  always_comb begin
    nxt_r = r_ff;
    dv    = '0;
    if (r_ff.blank != 5'h00) begin
      nxt_r.blank = r_ff.blank - 5'h01;
    end
    case (r_ff.st)
      CH_ON: begin
        if (run_i && trip_i && r_ff.blank == 5'h00) begin // R4
          nxt_r.st   = CH_OFF; // R1
          nxt_r.acc  = '0;
          nxt_r.zoff = 1'b0;
        end
      end
      CH_OFF: begin
        nxt_r.acc = r_ff.acc + ACC_STEP; // R2
        if (zero_i) begin
          nxt_r.zoff = 1'b1; // R12
        end
        if (!run_i || nxt_r.acc >= {1'b0, ohms_i}) begin
          nxt_r.st = CH_ON; // R1
        end
      end
      default: nxt_r.st = CH_ON;
    endcase
    fast = {nxt_r.acc, 4'h0} < 21'(ohms_i) * 21'(FAST_NUM); // R10
    // bridge drive for the chosen phase of the cycle
    if (!run_i || lvl_i.mag == MAG_ZERO) begin
      dv = '0;
    end else if (nxt_r.st == CH_ON) begin
      dv = lvl_i.neg ? 4'b0110 : 4'b1001;
    end else if (nxt_r.zoff) begin
      dv = '0; // R12
    end else if (mixed_i && fast) begin
      dv = lvl_i.neg ? 4'b1001 : 4'b0110; // R10 R11
    end else begin
      dv = 4'b0101; // R11
    end
    if (dv != r_ff.drv) begin
      nxt_r.blank = BLANK_LOAD; // R4
    end
    nxt_r.drv = dv;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '{st: CH_ON, acc: '0, blank: '0, zoff: 1'b0, drv: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign drv_o = r_ff.drv;

endmodule // sttc_chop

//--- verification/sttc_props.sv
`timescale 1ns/1ps
module sttc_props
  import sttc_pkg::*;
(
  input wire logic     clk_i,
  input wire logic     rst_i,
  input wire logic     wb_ack_o,
  input wire logic     step_i,
  input wire logic     outputs_off_i,
  input wire logic     translator_rst_n_i,
  input wire logic     overtemp_i,
  input wire logic     sink_gate_regulator_fault_i,
  input wire logic     undervoltage_lockout_i,
  input sttc_drv_t     bridge1_o,
  input sttc_drv_t     bridge2_o,
  input sttc_dac_t     dac1_o,
  input sttc_dac_t     dac2_o,
  input wire logic [2:0] pos_o,
  input wire logic     home_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // stop causes that have settled leave both bridges dark
  property p_off; outputs_off_i[*7] |-> {bridge1_o, bridge2_o} == 8'h00; endproperty
  property p_temp; overtemp_i[*7] |-> {bridge1_o, bridge2_o} == 8'h00; endproperty
  property p_reg;
    sink_gate_regulator_fault_i[*7] |-> {bridge1_o, bridge2_o} == 8'h00;
  endproperty
  property p_lockout;
    undervoltage_lockout_i[*7] |-> pos_o == HOME_POS && {bridge1_o, bridge2_o} == 8'h00;
  endproperty
  property p_rstn;
    !translator_rst_n_i[*7] |-> home_o && {bridge1_o, bridge2_o} == 8'h00;
  endproperty
  // odd index is a full-step point, even index has one phase at zero
  property p_lvl;
    pos_o[0] ? (dac1_o.pct == PCT_707 && dac2_o.pct == PCT_707)
             : ((dac1_o.pct == PCT_ZERO) != (dac2_o.pct == PCT_ZERO));
  endproperty
  // a move away from home only follows a step edge a few cycles back
  property p_step;
    $changed(pos_o) && !home_o |-> $past(step_i, 3) || $past(step_i, 4) || $past(step_i, 5);
  endproperty
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_off: assert property (p_off) else $error("bridge on while disabled");
  a_temp: assert property (p_temp) else $error("bridge on while hot");
  a_reg: assert property (p_reg) else $error("bridge on at regulator fault");
  a_lockout: assert property (p_lockout) else $error("lockout not honoured");
  a_rstn: assert property (p_rstn) else $error("translator reset not honoured");
  a_lvl: assert property (p_lvl) else $error("level table broken");
  a_step: assert property (p_step) else $error("move without step");
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  c_off: cover property (outputs_off_i[*7]);
  c_step: cover property ($changed(pos_o) && !home_o);
  c_ack: cover property (wb_ack_o);
endmodule // sttc_props
bind sttc_top sttc_props u_props (.clk_i, .rst_i, .wb_ack_o, .step_i, .outputs_off_i,
  .translator_rst_n_i, .overtemp_i, .sink_gate_regulator_fault_i, .undervoltage_lockout_i,
  .bridge1_o, .bridge2_o, .dac1_o, .dac2_o, .pos_o, .home_o);

//--- verification/sttc_ctrl_model.sv
`timescale 1ns/1ps
module sttc_ctrl_model (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic up_i,
  input  wire logic half_i,
  output logic      step_o,
  output logic      dir_o,
  output logic      res_o,
  output logic      done_o
);
  int cnt_ff = 0;
  initial begin
    step_o = 0;
    dir_o = 1;
    res_o = 1;
    done_o = 0;
  end
  // settle dir and size, then one step pulse, then report done
  always @(posedge clk_i) begin
    done_o <= (cnt_ff == 16);
    if (cnt_ff == 0 && go_i) begin
      dir_o <= up_i;
      res_o <= half_i;
    end
    if (cnt_ff != 0 || go_i)
      cnt_ff <= (cnt_ff == 16) ? 0 : cnt_ff + 1;
    if (cnt_ff == 5)
      step_o <= 1'b1;
    if (cnt_ff == 10)
      step_o <= 1'b0;
  end
endmodule // sttc_ctrl_model

//--- verification/sttc_top_tb.sv
`timescale 1ns/1ps
module sttc_top_tb;
  import sttc_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        we = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        go = 0;
  logic        up = 1;
  logic        half = 1;
  logic        off = 0;
  logic        rst_n = 1;
  logic [2:0]  flt = 3'h0;
  logic        lockout = 0;
  logic        tpin = 0;
  logic [1:0]  trip = 2'h0;
  logic [1:0]  zero = 2'h0;
  wire         step, dir, res, done, ack, home;
  wire  [31:0] dat_o;
  wire  [2:0]  pos;
  sttc_drv_t   b1, b2;
  sttc_dac_t   d1, d2;
  int          errors = 0;
  int          checked = 0;
  logic [14:0] tab [8] = '{15'h2710, 15'h1b9f, 15'h0, 15'h5b9f, 15'h6710, 15'h5b9f, 15'h0,
                          15'h1b9f};
  sttc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .step_i(step), .dir_i(dir), .resolution_select_i(res), .outputs_off_i(off),
    .translator_rst_n_i(rst_n), .overtemp_i(flt[0]), .gate_drive_reservoir_low_i(flt[1]),
    .sink_gate_regulator_fault_i(flt[2]), .undervoltage_lockout_i(lockout),
    .off_time_timing_pin_high_i(tpin), .trip_i(trip), .zero_i(zero), .bridge1_o(b1),
    .bridge2_o(b2), .dac1_o(d1), .dac2_o(d2), .pos_o(pos), .home_o(home));
  sttc_ctrl_model ctl (.clk_i(clk_i), .go_i(go), .up_i(up), .half_i(half), .step_o(step),
    .dir_o(dir), .res_o(res), .done_o(done));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) errors++;
    rdat = dat_o;
    cyc <= 0;
    we <= 0;
  endtask
  task automatic stp(input logic u, input logic h);
    int n = 0;
    @(posedge clk_i);
    up <= u;
    half <= h;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (done !== 1'b1) errors++;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic pchk(input logic [2:0] p);
    chk(pos, p);
    chk(d1, tab[p]);
    chk(d2, tab[p - 3'h2]);
  endtask
  task automatic t_chop;
    int n = 0;
    logic slow = 0;
    wb(1, REG_TIMING, 32'h14a);
    while (b1 !== 4'h9 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    repeat (30) @(posedge clk_i);
    trip <= 2'h1;
    n = 0;
    while (b1 === 4'h9 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    trip <= 2'h0;
    chk(b1, 4'h6);
    n = 0;
    while (b1 !== 4'h9 && n < 40) begin
      slow |= (b1 === 4'h5);
      @(posedge clk_i);
      n++;
    end
    chk(n, 10);
    chk(slow, 1);
    // trip raised right after the drive change must be masked
    trip <= 2'h1;
    zero <= 2'h1;
    repeat (20) @(posedge clk_i);
    chk(b1, 4'h9);
    repeat (12) @(posedge clk_i);
    chk(b1, 4'h0);
    trip <= 2'h0;
    zero <= 2'h0;
  endtask
  task automatic t_faults;
    for (int k = 0; k < 3; k++) begin
      flt <= 3'(1 << k);
      repeat (8) @(posedge clk_i);
      chk({b1, b2}, 0);
      flt <= 3'h0;
      repeat (40) @(posedge clk_i);
      chk(b1, 4'h9);
    end
    lockout <= 1;
    repeat (8) @(posedge clk_i);
    pchk(3'h1);
    lockout <= 0;
  endtask
  // timing pin high falls back to the default off-time
  task automatic t_tpin;
    int n = 0;
    tpin <= 1;
    repeat (40) @(posedge clk_i);
    trip <= 2'h1;
    while (b1 === 4'h9 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    trip <= 2'h0;
    n = 0;
    while (b1 !== 4'h9 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, OFF_DEFAULT_US * 1000 / CLK_NS);
    wb(0, REG_STATUS, 0);
    chk(rdat[12], 1);
    tpin <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    repeat (8) @(posedge clk_i);
    pchk(3'h1);
    chk(home, 1);
    wb(0, REG_TIMING, 0);
    chk(rdat, 32'h60ae);
    wb(0, REG_LEVELS, 0);
    chk(rdat, {1'b0, tab[3'h7], 1'b0, tab[3'h1]});
    wb(0, 4'hc, 0);
    chk(rdat, 0);
    t_chop;
    for (int k = 2; k < 10; k++) begin
      stp(1, 1);
      pchk(3'(k));
    end
    stp(0, 1);
    pchk(3'h0);
    rst_n <= 0;
    repeat (8) @(posedge clk_i);
    stp(1, 1);
    pchk(3'h1);
    rst_n <= 1;
    repeat (8) @(posedge clk_i);
    stp(1, 1);
    wb(0, REG_STATUS, 0);
    chk(rdat[4:3], 2'b01);
    stp(1, 1);
    wb(0, REG_STATUS, 0);
    chk(rdat[4:3], 2'b10);
    stp(1, 0);
    pchk(3'h5);
    stp(1, 1);
    stp(1, 0);
    pchk(3'h7);
    off <= 1;
    stp(1, 1);
    chk({b1, b2}, 0);
    pchk(3'h0);
    off <= 0;
    t_faults;
    t_tpin;
    test_done;
  end
  // cut a hang short
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    test_done;
  end
endmodule // sttc_top_tb
